// File: core/usr_shift4.sv
/*
 * Four-stage bidirectional universal shift register with a word stream of
 * every content changed by a load or shift through a two-entry buffer.
 * Assumes mode, serial and parallel inputs are synchronous to i_clk and that
 * each rising edge of i_clk with i_step, o_step_ready and i_clear_n high is one register clock edge.
 */
// Operation
// - Four stages, first to last, each with its parallel output and input.
// - Clear low forces all stage outputs low at once, overriding everything.
// - Both selects high with clear high loads parallel inputs on rising edge.
// - Parallel load ignores both serial inputs.
// - Select-low high, select-high low shifts from first stage toward last.
// - In right shift the first stage takes the right serial input.
// - Left shift moves last toward first; last stage takes left serial input.
// - Both selects low keeps all stages unchanged.
// - Stage contents change only on rising clock edges, apart from clear.
`timescale 1ns/1ps

module usr_shift4
	import usr_pkg::*;
(
	input  wire logic                  i_clk,              // System clock, 20 MHz
	input  wire logic                  i_rst,              // Synchronous reset, active high
	input  wire logic                  i_clear_n,          // Direct clear, active low
	input  wire logic                  i_step,             // Register clock edge enable
	input  wire logic                  i_mode_select_low,  // Mode select, low bit
	input  wire logic                  i_mode_select_high, // Mode select, high bit
	input  wire logic                  i_serial_right,     // Serial input for right shift
	input  wire logic                  i_serial_left,      // Serial input for left shift
	input  wire logic [USR_STAGES-1:0] i_par_in,           // Parallel inputs, bit 0 first
	output logic                       o_step_ready,       // Step is accepted this cycle
	output logic                       o_stage_out_first,  // First stage output
	output logic                       o_stage_out_second, // Second stage output
	output logic                       o_stage_out_third,  // Third stage output
	output logic                       o_stage_out_last,   // Last stage output
	output logic [USR_STAGES-1:0]      o_stage_out,        // All stage outputs, bit 0 first
	output logic                       o_word_valid,       // Buffered content word valid
	output logic [USR_STAGES-1:0]      o_word_data,        // Buffered content word
	input  wire logic                  i_word_ready        // Receiver takes word
);

	typedef struct packed {
		logic [USR_STAGES-1:0] stage;
	} usr_state_t;

	usr_state_t            st_reg;
	usr_state_t            st_next;
	usr_op_t               op;
	logic [USR_STAGES-1:0] load_val;
	logic [USR_STAGES-1:0] right_val;
	logic [USR_STAGES-1:0] left_val;
	logic [USR_STAGES-1:0] shifted;
	logic                  buf_ready;
	logic                  edge_ok;
	logic                  changes;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	always_comb begin
		case ({i_mode_select_high, i_mode_select_low})
			USR_SEL_LOAD:  op = USR_OP_LOAD;
			USR_SEL_RIGHT: op = USR_OP_RIGHT;
			USR_SEL_LEFT:  op = USR_OP_LEFT;
			USR_SEL_HOLD:  op = USR_OP_HOLD;
			default:       op = USR_OP_HOLD;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-stage candidate values

	for (genvar g = 0; g < USR_STAGES; g++) begin : g_stage
		// Load takes only the parallel input, never a serial one
		assign load_val[g] = i_par_in[g];
		if (g == USR_FIRST) begin : g_first
			assign right_val[g] = i_serial_right;
		end else begin : g_right
			assign right_val[g] = st_reg.stage[g-1];
		end
		if (g == USR_LAST) begin : g_last
			assign left_val[g] = i_serial_left;
		end else begin : g_left
			assign left_val[g] = st_reg.stage[g+1];
		end
	end

	always_comb begin
		case (op)
			USR_OP_LOAD:  shifted = load_val;
			USR_OP_RIGHT: shifted = right_val;
			USR_OP_LEFT:  shifted = left_val;
			USR_OP_HOLD:  shifted = st_reg.stage;
			default:      shifted = st_reg.stage;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge acceptance: a full buffer stalls the step so no word is lost

	assign o_step_ready = buf_ready;
	assign edge_ok      = i_step && buf_ready && i_clear_n;
	assign changes      = edge_ok && (op != USR_OP_HOLD);

	always_comb begin
		st_next = st_reg;
		if (edge_ok) begin
			st_next.stage = shifted;
		end
		if (!i_clear_n) begin
			st_next.stage = USR_STAGE_RST;
		end
		if (i_rst) begin
			st_next.stage = USR_STAGE_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs: clear masks the stages at once, before the next edge

	assign o_stage_out        = st_reg.stage & {USR_STAGES{i_clear_n}};
	assign o_stage_out_first  = o_stage_out[USR_FIRST];
	assign o_stage_out_second = o_stage_out[1];
	assign o_stage_out_third  = o_stage_out[2];
	assign o_stage_out_last   = o_stage_out[USR_LAST];

	////////////////////////////////////////////////////////////////////////////////
	// Content stream: each changing edge pushes the new content

	usr_buf2 u_buf (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (changes),
		.i_data  (shifted),
		.o_ready (buf_ready),
		.o_valid (o_word_valid),
		.o_data  (o_word_data),
		.i_ready (i_word_ready)
	);

endmodule

// File: common/usr_pkg.sv
/*
 * Constants for the four-stage universal shift register and its word buffer.
 * Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
 */
package usr_pkg;

	localparam int unsigned USR_STAGES    = 4;
	localparam int unsigned USR_BUF_DEPTH = 2;
	localparam int unsigned USR_PTR_W     = 1;
	localparam int unsigned USR_CNT_W     = 2;

	// Stage positions: first stage is bit 0, last stage is bit 3
	localparam int unsigned USR_FIRST = 0;
	localparam int unsigned USR_LAST  = USR_STAGES - 1;

	localparam logic [USR_STAGES-1:0] USR_STAGE_RST = 4'h0;
	localparam logic [USR_CNT_W-1:0]  USR_CNT_FULL  = 2'h2;
	localparam logic [USR_CNT_W-1:0]  USR_CNT_ZERO  = 2'h0;

	// Select encoding {mode_select_high, mode_select_low}
	localparam logic [1:0] USR_SEL_HOLD  = 2'h0;
	localparam logic [1:0] USR_SEL_RIGHT = 2'h1;
	localparam logic [1:0] USR_SEL_LEFT  = 2'h2;
	localparam logic [1:0] USR_SEL_LOAD  = 2'h3;

	// Decoded operation, one-hot
	typedef enum logic [3:0] {
		USR_OP_HOLD  = 4'h1,
		USR_OP_RIGHT = 4'h2,
		USR_OP_LEFT  = 4'h4,
		USR_OP_LOAD  = 4'h8
	} usr_op_t;

endpackage

// File: core/usr_buf2.sv
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset shared with its user.
 */
`timescale 1ns/1ps

module usr_buf2
	import usr_pkg::*;
(
	input  wire logic                  i_clk,     // System clock
	input  wire logic                  i_rst,     // Synchronous reset, active high
	input  wire logic                  i_valid,   // Write side word valid
	input  wire logic [USR_STAGES-1:0] i_data,    // Write side word
	output logic                       o_ready,   // Write side can accept
	output logic                       o_valid,   // Read side word valid
	output logic [USR_STAGES-1:0]      o_data,    // Read side word
	input  wire logic                  i_ready    // Read side takes word
);

	typedef struct packed {
		logic [USR_BUF_DEPTH-1:0][USR_STAGES-1:0] mem;
		logic [USR_PTR_W-1:0]                     wr_ptr;
		logic [USR_PTR_W-1:0]                     rd_ptr;
		logic [USR_CNT_W-1:0]                     count;
	} usr_buf_t;

	usr_buf_t st_reg;
	usr_buf_t st_next;
	logic     push;
	logic     pop;

	////////////////////////////////////////////////////////////////////////////////

	assign o_ready = (st_reg.count != USR_CNT_FULL);
	assign o_valid = (st_reg.count != USR_CNT_ZERO);
	assign o_data  = st_reg.mem[st_reg.rd_ptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr_ptr] = i_data;
			st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'h2: st_next.count = st_reg.count + 2'h1;
			2'h1: st_next.count = st_reg.count - 2'h1;
			default: st_next.count = st_reg.count;
		endcase
		if (i_rst) begin
			st_next = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

endmodule

// File: sim/usr_shift4_monitor.sv
/* Port checker for usr_shift4.
   Assumes one clock and a synchronous reset; bound to every instance. */
`timescale 1ns/1ps
module usr_shift4_monitor
	import usr_pkg::*;
(
	input wire logic       i_clk, i_rst, i_clear_n, i_step,        // Clock, reset, clear, step
	input wire logic       i_mode_select_low, i_mode_select_high,  // Mode selects
	input wire logic       i_serial_right, i_serial_left,          // Serial inputs
	input wire logic [3:0] i_par_in, o_stage_out, o_word_data,      // Parallel in, stages, word
	input wire logic       o_step_ready, o_word_valid,             // Handshakes
	input wire logic       o_stage_out_first, o_stage_out_second,  // Single stage outputs
	input wire logic       o_stage_out_third, o_stage_out_last     // Single stage outputs
);
	wire logic [1:0] md  = {i_mode_select_high, i_mode_select_low};
	wire logic       acc = i_step && o_step_ready && i_clear_n;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_stage_vec: assert property (o_stage_out == {o_stage_out_last, o_stage_out_third,
		o_stage_out_second, o_stage_out_first}) else $error("stage outputs disagree");
	a_clear_mask: assert property (!i_clear_n |-> o_stage_out == 4'h0)
		else $error("clear did not mask");
	a_clear_wins: assert property (!i_clear_n |=> o_stage_out == 4'h0)
		else $error("clear did not empty stages");
	a_load_word: assert property (acc && md == USR_SEL_LOAD |=>
		!i_clear_n || o_stage_out == $past(i_par_in)) else $error("load wrong");
	a_shift_right: assert property (acc && md == USR_SEL_RIGHT |=> !i_clear_n ||
		o_stage_out == {$past(o_stage_out[2:0]), $past(i_serial_right)}) else $error("right wrong");
	a_shift_left: assert property (acc && md == USR_SEL_LEFT |=> !i_clear_n ||
		o_stage_out == {$past(i_serial_left), $past(o_stage_out[3:1])}) else $error("left wrong");
	a_hold_still: assert property (i_clear_n && !(acc && md != USR_SEL_HOLD) |=>
		!i_clear_n || $stable(o_stage_out)) else $error("stages moved");
	a_push_load: assert property (acc && md == USR_SEL_LOAD && !o_word_valid |=>
		o_word_valid && o_word_data == $past(i_par_in)) else $error("word not pushed");
endmodule
bind usr_shift4 usr_shift4_monitor i_mon (.*);

// File: sim/usr_recv.sv
/* Receiver of the content word stream.
   Assumes the bench drives i_stall at falling edges. */
`timescale 1ns/1ps
module usr_recv (
	input  wire logic       i_clk,   // System clock
	input  wire logic       i_rst,   // Synchronous reset
	input  wire logic       i_stall, // Hold off taking words
	input  wire logic       i_valid, // Word offered
	input  wire logic [3:0] i_data,  // Offered word
	output logic            o_ready  // Word taken at this edge
);
	logic [3:0] got[$];
	assign o_ready = !i_stall;
	always @(posedge i_clk)
		if (!i_rst && i_valid && o_ready) got.push_back(i_data);
endmodule

// File: sim/tb_usr_shift4.sv
/* Self-checking bench for usr_shift4.
   Assumes usr_recv as the word receiver. */
`timescale 1ns/1ps
module tb_usr_shift4;
	import usr_pkg::*;
	logic i_clk = 0, i_rst = 1, i_clear_n = 1, i_step = 0, stall = 0;
	logic i_mode_select_low = 0, i_mode_select_high = 0, i_serial_right = 0, i_serial_left = 0;
	logic [3:0] i_par_in = 4'h0, o_stage_out, o_word_data, expv = 4'h0;
	logic o_step_ready, o_stage_out_first, o_stage_out_second, o_stage_out_third;
	logic o_stage_out_last, o_word_valid;
	wire logic i_word_ready;
	logic [3:0] sent[$];
	int num_errors = 0, checks_done = 0, cyc = 0;
	usr_shift4 i_dut (.*);
	usr_recv i_rcv (.i_clk, .i_rst, .i_stall(stall), .i_valid(o_word_valid),
		.i_data(o_word_data), .o_ready(i_word_ready));
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) if (++cyc > 3000) begin
		num_errors++;
		final_report();
	end
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One register clock edge, held until the step is accepted
	task automatic step(input logic [1:0] md, input logic [3:0] par, input logic sr, sl);
		@(negedge i_clk);
		{i_mode_select_high, i_mode_select_low} = md;
		i_par_in = par;
		i_serial_right = sr;
		i_serial_left = sl;
		i_step = 1;
		for (int n = 0; n < 50 && !o_step_ready; n++) @(negedge i_clk);
		@(negedge i_clk);
		i_step = 0;
		case (md)
			USR_SEL_LOAD: expv = par;
			USR_SEL_RIGHT: expv = {expv[2:0], sr};
			USR_SEL_LEFT: expv = {sl, expv[3:1]};
			default: expv = expv;
		endcase
		if (md != USR_SEL_HOLD) sent.push_back(expv);
		chk(o_stage_out, expv);
		chk({o_stage_out_last, o_stage_out_third, o_stage_out_second, o_stage_out_first}, expv);
	endtask
	task automatic t_modes();
		step(USR_SEL_LOAD, 4'hA, 1, 1);
		step(USR_SEL_RIGHT, 4'h5, 1, 0);
		step(USR_SEL_RIGHT, 4'hF, 0, 1);
		step(USR_SEL_LEFT, 4'h0, 0, 1);
		step(USR_SEL_LEFT, 4'hF, 1, 0);
		step(USR_SEL_HOLD, 4'h3, 1, 1);
		step(USR_SEL_LOAD, 4'hF, 0, 0);
	endtask
	task automatic t_idle();
		@(negedge i_clk);
		i_par_in = ~expv;
		{i_mode_select_high, i_mode_select_low} = USR_SEL_LOAD;
		repeat (4) @(negedge i_clk);
		chk(o_stage_out, expv);
	endtask
	task automatic t_clear();
		@(negedge i_clk);
		i_clear_n = 0;
		i_step = 1;
		#1 chk(o_stage_out, 4'h0);
		@(negedge i_clk);
		i_step = 0;
		i_clear_n = 1; // Released well before the next step
		#1 chk(o_stage_out, 4'h0);
		expv = 4'h0;
	endtask
	task automatic t_stall();
		@(negedge i_clk);
		stall = 1;
		step(USR_SEL_RIGHT, 4'h0, 1, 0);
		step(USR_SEL_RIGHT, 4'h0, 1, 0);
		chk({3'h0, o_step_ready}, 4'h0);
		fork
			step(USR_SEL_LEFT, 4'h0, 0, 1);
			begin
				repeat (5) @(negedge i_clk);
				chk(o_stage_out, expv);
				stall = 0;
			end
		join
	endtask
	task automatic t_words();
		repeat (4) @(negedge i_clk);
		chk(4'(i_rcv.got.size()), 4'(sent.size()));
		foreach (sent[k]) chk(i_rcv.got[k], sent[k]);
	endtask
	task automatic final_report();
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge i_clk);
		i_rst = 0;
		t_modes();
		t_idle();
		t_clear();
		t_stall();
		t_words();
		final_report();
	end
endmodule
